// ### ptpc_consts.svh
// Register offsets, field positions, reset values and pin timing for the periodic timer
// Included by the design modules, the monitor and the bench; definitions only
`ifndef PTPC_CONSTS_SVH
`define PTPC_CONSTS_SVH

`define PTPC_ADDR_W        6
`define PTPC_OFS_CTRL      6'h00
`define PTPC_OFS_PERIOD    6'h04
`define PTPC_OFS_COMPARE   6'h08
`define PTPC_OFS_STATUS    6'h0C
`define PTPC_OFS_COUNT     6'h10

`define PTPC_CTL_RUN       0
`define PTPC_CTL_MODE_LO   1
`define PTPC_CTL_MODE_HI   2
`define PTPC_CTL_PIN_LO    3
`define PTPC_CTL_PIN_HI    4
`define PTPC_CTL_CCLR      5
`define PTPC_CTL_OINIT     6
`define PTPC_CTL_OINV      7
`define PTPC_CTL_CAPSRC    8
`define PTPC_CTL_W         9
`define PTPC_CTL_RESET     9'h000

`define PTPC_STS_AFLAG     0
`define PTPC_STS_PFLAG     1
`define PTPC_STS_W         2

`define PTPC_PRESCALE_RESET 8'h00
`define PTPC_SYNC_STAGES   3

`define PTPC_RESP_OKAY     2'h0
`define PTPC_RESP_SLVERR   2'h2

`endif

// ### ptpc_pkg.sv
// Types shared by the periodic timer modules
// Pairs with ptpc_consts.svh, which holds the numeric constants
package ptpc_pkg;

  typedef enum logic [1:0]
  {
    PTPC_MODE_COMPARE = 2'h0,
    PTPC_MODE_CAPTURE = 2'h1,
    PTPC_MODE_PWM     = 2'h2,
    PTPC_MODE_TIMER   = 2'h3
  } ptpc_mode_e;

  typedef enum logic [1:0]
  {
    PTPC_PIN_LOW    = 2'h0,
    PTPC_PIN_HIGH   = 2'h1,
    PTPC_PIN_ACTIVE = 2'h2,
    PTPC_PIN_PULSE  = 2'h3
  } ptpc_pin_e;

endpackage : ptpc_pkg

// ### ptpc_sync.sv
// Three-flop synchroniser with a two-stage agreement filter for one pin
// Assumes the pin is asynchronous to aclk
`timescale 1ns/1ps
`include "ptpc_consts.svh"

module ptpc_sync
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  import ptpc_pkg::*;

  logic [`PTPC_SYNC_STAGES-1:0] stage;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      stage <= '0;
    else
      stage <= {stage[`PTPC_SYNC_STAGES-2:0], pin};
  end

  // Level changes only when the second and third stages agree
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      level <= 1'b0;
    else if (stage[1] == stage[2])
      level <= stage[2];
  end

  assign rise = (stage[1] == stage[2]) && stage[2] && !level;
  assign fall = (stage[1] == stage[2]) && !stage[2] && level;

endmodule : ptpc_sync

// ### ptpc_axil.sv
// AXI4-Lite slave front end: decodes one write and one read at a time
// Assumes a single master; register storage lives in the timer core
`timescale 1ns/1ps
`include "ptpc_consts.svh"

module ptpc_axil
(
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic [`PTPC_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [`PTPC_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  output logic                         wr_en,
  output logic [`PTPC_ADDR_W-1:0]      wr_addr,
  output logic [31:0]                  wr_data,
  output logic [3:0]                   wr_strb,
  input  wire logic                    wr_ok,
  output logic                         rd_en,
  output logic [`PTPC_ADDR_W-1:0]      rd_addr,
  input  wire logic [31:0]             rd_data,
  input  wire logic                    rd_ok
);
  import ptpc_pkg::*;

  logic                    aw_held;
  logic                    w_held;
  logic [`PTPC_ADDR_W-1:0] held_addr;
  logic [31:0]             held_data;
  logic [3:0]              held_strb;

  // The core sees the held copy, or the bus itself when that half arrives in the write cycle
  assign wr_addr = aw_held ? held_addr : s_axi_awaddr;
  assign wr_data = w_held ? held_data : s_axi_wdata;
  assign wr_strb = w_held ? held_strb : s_axi_wstrb;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_en = (aw_held || s_axi_awvalid) && (w_held || s_axi_wvalid) && !s_axi_bvalid;

  // Address and data may arrive in either order; each is held until both are in
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      held_addr <= '0;
      held_data <= '0;
      held_strb <= '0;
    end
    else if (wr_en)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        held_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held  <= 1'b1;
        held_data <= s_axi_wdata;
        held_strb <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `PTPC_RESP_OKAY;
    end
    else if (wr_en)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? `PTPC_RESP_OKAY : `PTPC_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  assign s_axi_arready = !s_axi_rvalid;
  assign rd_en   = s_axi_arvalid && s_axi_arready;
  assign rd_addr = s_axi_araddr;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= `PTPC_RESP_OKAY;
    end
    else if (rd_en)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_ok ? rd_data : 32'h00000000;
      s_axi_rresp  <= rd_ok ? `PTPC_RESP_OKAY : `PTPC_RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule : ptpc_axil

// ### ptpc_timer.sv
// Periodic timer: edge-aligned PWM, single-pulse output and capture input
// Assumes AXI4-Lite register access and asynchronous trigger/capture pins
//
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "ptpc_consts.svh"

module ptpc_timer
#(
  parameter int CNT_W = 10
)
(
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic [`PTPC_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [`PTPC_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire logic                    external_clock_pin,
  input  wire logic                    capture_input_pin,
  output logic                         timer_out,
  output logic                         timer_out_oe
);
  import ptpc_pkg::*;

  if (CNT_W != 10 && CNT_W != 16)
  begin : g_bad_width
    $error("ptpc_timer: CNT_W must be 10 or 16");
  end

  logic                    wr_en, wr_ok, rd_en, rd_ok;
  logic [`PTPC_ADDR_W-1:0] wr_addr, rd_addr;
  logic [31:0]             wr_data, rd_data;
  logic [3:0]              wr_strb;

  ptpc_axil u_bus
  (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .wr_en, .wr_addr, .wr_data, .wr_strb, .wr_ok, .rd_en, .rd_addr, .rd_data, .rd_ok
  );

  logic ext_level, ext_rise, ext_fall;
  logic cap_level, cap_rise, cap_fall;

  ptpc_sync u_sync_ext
  (
    .aclk, .aresetn, .pin (external_clock_pin), .level (ext_level), .rise (ext_rise), .fall (ext_fall)
  );
  ptpc_sync u_sync_cap
  (
    .aclk, .aresetn, .pin (capture_input_pin), .level (cap_level), .rise (cap_rise), .fall (cap_fall)
  );

  // Control register fields
  logic [`PTPC_CTL_W-1:0] timer_control_one;
  logic [CNT_W-1:0]       period_value, compare_a_value, count;
  logic [7:0]             prescale, tick_cnt;
  logic                   compare_a_flag, compare_p_flag, run_prev, pulse_out, pwm_level;

  logic       count_run_bit, clear_source_select, output_initial_level, output_invert, capture_source_select;
  ptpc_mode_e mode;
  ptpc_pin_e  pin_fn;

  assign count_run_bit         = timer_control_one[`PTPC_CTL_RUN];
  assign mode                  = ptpc_mode_e'(timer_control_one[`PTPC_CTL_MODE_HI:`PTPC_CTL_MODE_LO]);
  assign pin_fn                = ptpc_pin_e'(timer_control_one[`PTPC_CTL_PIN_HI:`PTPC_CTL_PIN_LO]);
  assign clear_source_select   = timer_control_one[`PTPC_CTL_CCLR];
  assign output_initial_level  = timer_control_one[`PTPC_CTL_OINIT];
  assign output_invert         = timer_control_one[`PTPC_CTL_OINV];
  assign capture_source_select = timer_control_one[`PTPC_CTL_CAPSRC];

  logic is_pwm, is_pulse, is_cap;
  assign is_pwm   = (mode == PTPC_MODE_PWM) && (pin_fn != PTPC_PIN_PULSE);
  assign is_pulse = (mode == PTPC_MODE_PWM) && (pin_fn == PTPC_PIN_PULSE);
  assign is_cap   = (mode == PTPC_MODE_CAPTURE);

  // Timer tick: one per (prescale+1) bus clocks
  logic tick;
  assign tick = count_run_bit && (tick_cnt == prescale);

  logic run_rise;
  assign run_rise = count_run_bit && !run_prev;

  // Period zero wraps at the full count, so matching zero is never a wrap point
  // A run rise restarts from zero in PWM, pulse and capture modes, so the stale count may not match in that cycle
  logic p_match, a_match;
  assign p_match = tick && !run_rise && (period_value != '0)
                   && (count == period_value - CNT_W'(1));
  assign a_match = tick && !run_rise && (count == compare_a_value - CNT_W'(1));

  // Capture edge selection
  logic src_rise, src_fall, cap_edge;
  assign src_rise = capture_source_select ? ext_rise : cap_rise;
  assign src_fall = capture_source_select ? ext_fall : cap_fall;
  always_comb
  begin
    unique case (pin_fn)
      PTPC_PIN_LOW:    cap_edge = src_rise;
      PTPC_PIN_HIGH:   cap_edge = src_fall;
      PTPC_PIN_ACTIVE: cap_edge = src_rise || src_fall;
      PTPC_PIN_PULSE:  cap_edge = 1'b0;
    endcase
  end
  logic do_capture;
  assign do_capture = is_cap && count_run_bit && cap_edge;

  // Pulse trigger from the external clock pin
  logic ext_trigger;
  assign ext_trigger = is_pulse && !count_run_bit && ext_rise;

  logic pulse_end;
  assign pulse_end = is_pulse && count_run_bit && a_match;

  logic wr_ctrl;
  assign wr_ctrl = wr_en && (wr_addr == `PTPC_OFS_CTRL);

  assign wr_ok = (wr_addr == `PTPC_OFS_CTRL) || (wr_addr == `PTPC_OFS_PERIOD)
                 || (wr_addr == `PTPC_OFS_COMPARE) || (wr_addr == `PTPC_OFS_STATUS)
                 || (wr_addr == `PTPC_OFS_COUNT);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      timer_control_one <= `PTPC_CTL_RESET;
      prescale          <= `PTPC_PRESCALE_RESET;
    end
    else
    begin
      if (wr_ctrl && wr_strb[0])
        timer_control_one[7:0] <= wr_data[7:0];
      if (wr_ctrl && wr_strb[1])
        timer_control_one[`PTPC_CTL_CAPSRC] <= wr_data[`PTPC_CTL_CAPSRC];
      if (wr_ctrl && wr_strb[2])
        prescale <= wr_data[23:16];
      // Hardware run changes win over the same-cycle software write
      if (ext_trigger)
        timer_control_one[`PTPC_CTL_RUN] <= 1'b1;
      else if (pulse_end)
        timer_control_one[`PTPC_CTL_RUN] <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      period_value <= '0;
    else if (wr_en && wr_addr == `PTPC_OFS_PERIOD)
      period_value <= CNT_W'(wr_data);
  end

  // Capture overrides a same-cycle software write
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      compare_a_value <= '0;
    else if (do_capture)
      compare_a_value <= count;
    else if (wr_en && wr_addr == `PTPC_OFS_COMPARE)
      compare_a_value <= CNT_W'(wr_data);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !count_run_bit || tick)
      tick_cnt <= '0;
    else
      tick_cnt <= tick_cnt + 8'h01;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      run_prev <= 1'b0;
    else
      run_prev <= count_run_bit;
  end

  // Counter
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count <= '0;
    else if (run_rise && (is_pulse || is_cap || is_pwm))
      count <= '0;
    else if (tick)
    begin
      if (is_pulse)
        count <= count + CNT_W'(1);
      else if (p_match && (is_pwm || is_cap || !clear_source_select))
        count <= '0;
      else if (!is_pwm && !is_cap && clear_source_select && a_match)
        count <= '0;
      else
        count <= count + CNT_W'(1);
    end
  end

  // Flags: hardware set wins over a write-one clear
  logic clr_a, clr_p;
  assign clr_a = wr_en && (wr_addr == `PTPC_OFS_STATUS) && wr_strb[0] && wr_data[`PTPC_STS_AFLAG];
  assign clr_p = wr_en && (wr_addr == `PTPC_OFS_STATUS) && wr_strb[0] && wr_data[`PTPC_STS_PFLAG];

  logic set_a, set_p;
  assign set_a = (is_pwm && a_match) || pulse_end || do_capture;
  assign set_p = (is_pwm || is_cap) && p_match;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      compare_a_flag <= 1'b0;
    else if (set_a)
      compare_a_flag <= 1'b1;
    else if (clr_a)
      compare_a_flag <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      compare_p_flag <= 1'b0;
    else if (set_p)
      compare_p_flag <= 1'b1;
    else if (clr_p)
      compare_p_flag <= 1'b0;
  end

  // PWM active phase: count below compare; compare at or above period stays active
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pwm_level <= 1'b0;
    else if (!count_run_bit)
      pwm_level <= 1'b0;
    else if (period_value == '0)
      pwm_level <= ({1'b0, count} < {1'b0, compare_a_value});
    else
      pwm_level <= (count < compare_a_value) || (compare_a_value >= period_value);
  end

  // Single pulse output: active between run rise and run fall
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pulse_out <= 1'b0;
    else
      pulse_out <= is_pulse && count_run_bit && !pulse_end;
  end

  logic next_out;
  always_comb
  begin
    next_out = 1'b0;
    if (is_pwm)
    begin
      unique case (pin_fn)
        PTPC_PIN_LOW:    next_out = 1'b0;
        PTPC_PIN_HIGH:   next_out = 1'b1;
        default:         next_out = (pwm_level ~^ output_initial_level) ^ output_invert;
      endcase
    end
    else if (is_pulse)
      next_out = pulse_out ^ output_invert;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      timer_out    <= 1'b0;
      timer_out_oe <= 1'b0;
    end
    else
    begin
      timer_out    <= next_out;
      timer_out_oe <= is_pwm || is_pulse;
    end
  end

  // Register read mux
  always_comb
  begin
    rd_data = 32'h00000000;
    rd_ok   = 1'b1;
    unique case (rd_addr)
      `PTPC_OFS_CTRL:    rd_data = {8'h00, prescale, 7'h00, timer_control_one};
      `PTPC_OFS_PERIOD:  rd_data = 32'(period_value);
      `PTPC_OFS_COMPARE: rd_data = 32'(compare_a_value);
      `PTPC_OFS_STATUS:  rd_data = {30'h0, compare_p_flag, compare_a_flag};
      `PTPC_OFS_COUNT:   rd_data = {29'h0, cap_level, ext_level, timer_out} |
                                   32'(count) << 16;
      default:           rd_ok   = 1'b0;
    endcase
  end

endmodule : ptpc_timer

// ### ptpc_timer_monitor.sv
// Port checks for ptpc_timer: bus answers, refused reads, pin enable by mode
// Bound into every ptpc_timer; follows the mode field from writes whose address and data are accepted in one cycle
`timescale 1ns/1ps
`include "ptpc_consts.svh"
module ptpc_timer_monitor
#(
  parameter int CNT_W = 10
)
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [5:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [5:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        timer_out,
  input wire logic        timer_out_oe
);
  logic [1:0] mode_q;
  wire        wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire        rd_go = s_axi_arvalid && s_axi_arready;
  always_ff @(posedge aclk)
    if (!aresetn)
      mode_q <= 2'h0;
    else if (wr_go && s_axi_awaddr == `PTPC_OFS_CTRL)
      mode_q <= s_axi_wdata[2:1];
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_write_answer: assert property (wr_go |=> s_axi_bvalid)
    else $error("write not answered");
  a_read_answer: assert property (rd_go |=> s_axi_rvalid)
    else $error("read not answered");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_unmapped_read: assert property (rd_go && s_axi_araddr > 6'h10 |=> s_axi_rresp == `PTPC_RESP_SLVERR)
    else $error("unmapped read accepted");
  a_capture_quiet: assert property ((mode_q == 2'h1) [*3] |-> !timer_out_oe)
    else $error("pin driven in capture");
  a_output_driven: assert property ((mode_q == 2'h2) [*3] |-> timer_out_oe)
    else $error("pin not driven");
  a_reset_quiet: assert property (disable iff (1'h0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !timer_out_oe)
    else $error("busy after reset");
  c_pulse: cover property (mode_q == 2'h2 ##1 $rose(timer_out));
  c_capture: cover property (mode_q == 2'h1 && rd_go);
  c_refused: cover property (rd_go && s_axi_araddr > 6'h10);
endmodule : ptpc_timer_monitor

bind ptpc_timer ptpc_timer_monitor #(.CNT_W(CNT_W)) i_mon
(
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer_out, .timer_out_oe
);

// ### ptpc_pins_model.sv
// Far side of the timer: trigger and capture pins
// Driven from the bench's clock; both pins rest low
`timescale 1ns/1ps
module ptpc_pins_model
(
  input  wire logic aclk,
  output logic      external_clock_pin,
  output logic      capture_input_pin
);
  initial
  begin
    external_clock_pin = 1'h0;
    capture_input_pin  = 1'h0;
  end
  // One high pulse, hold cycles long, on the external pin (sel 1) or capture pin
  task automatic blip(input logic sel, input int hold);
    @(posedge aclk);
    external_clock_pin <= sel;
    capture_input_pin  <= !sel;
    repeat (hold) @(posedge aclk);
    external_clock_pin <= 1'h0;
    capture_input_pin  <= 1'h0;
  endtask : blip
endmodule : ptpc_pins_model

// ### ptpc_timer_test.sv
// Self-checking bench for ptpc_timer: PWM, single pulse and capture over AXI4-Lite
// Pins come from ptpc_pins_model; the port monitor binds itself in
`timescale 1ns/1ps
`include "ptpc_consts.svh"
module ptpc_timer_test;
  localparam logic [5:0] A_CTL = `PTPC_OFS_CTRL;
  localparam logic [5:0] A_PER = `PTPC_OFS_PERIOD;
  localparam logic [5:0] A_CMP = `PTPC_OFS_COMPARE;
  localparam logic [5:0] A_STS = `PTPC_OFS_STATUS;
  localparam logic [5:0] A_CNT = `PTPC_OFS_COUNT;
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic [5:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, v, u;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, timer_out, timer_out_oe;
  logic        external_clock_pin, capture_input_pin;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          num_errors = 0, checks_done = 0, cycles = 0;

  ptpc_timer #(.CNT_W(10)) i_dut
  (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .external_clock_pin, .capture_input_pin, .timer_out, .timer_out_oe
  );
  ptpc_pins_model i_pins (.aclk, .external_clock_pin, .capture_input_pin);

  always #20 aclk = ~aclk;
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      close_out();
    end
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string w);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", w, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er = `PTPC_RESP_OKAY);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'h0;
    end
    while (s_axi_bvalid !== 1'h1);
    chk(s_axi_bresp, er, "bresp");
  endtask : wr

  task automatic rd(input logic [5:0] a, output logic [31:0] d, input logic [1:0] er = `PTPC_RESP_OKAY);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'h0;
    end
    while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    chk(s_axi_rresp, er, "rresp");
  endtask : rd

  task automatic rdchk(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e, input string w);
    logic [31:0] d;
    rd(a, d);
    chk(d & m, e, w);
  endtask : rdchk

  // Counts output-high cycles over n cycles, after skip settling cycles
  task automatic hichk(input int skip, input int n, input int e, input string w);
    int hi;
    hi = 0;
    repeat (skip) @(posedge aclk);
    // Sample mid-cycle, where the registered pin level has settled
    repeat (n)
    begin
      @(negedge aclk);
      hi += (timer_out === 1'h1);
    end
    @(posedge aclk);
    chk(hi, e, w);
  endtask : hichk

  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rdchk(A_STS, 32'h3, 32'h0, "status");
    rd(6'h14, v, `PTPC_RESP_SLVERR);
    chk(v, 32'h0, "unmapped");
    wr(6'h14, 32'h1, `PTPC_RESP_SLVERR);
    // PWM: mode 10, pin 10, initial level 1, clear select set
    wr(A_PER, 32'h8);
    wr(A_CMP, 32'h3);
    wr(A_CTL, 32'h75);
    hichk(4, 32, 12, "duty");
    rdchk(A_STS, 32'h3, 32'h3, "flags");
    wr(A_CTL, 32'hF5);
    hichk(4, 32, 20, "invert");
    wr(A_CTL, 32'h45);
    hichk(4, 32, 0, "forced");
    rd(A_CNT, v);
    rd(A_CNT, u);
    chk(v[31:16] !== u[31:16], 1'h1, "runs");
    wr(A_CMP, 32'h9);
    wr(A_CTL, 32'h55);
    hichk(4, 32, 32, "full");
    wr(A_PER, 32'h0);
    wr(A_CMP, 32'h200);
    hichk(4, 1024, 512, "long");
    // Single pulse: mode 10, pin 11, width 5
    wr(A_CTL, 32'h5C);
    wr(A_CMP, 32'h5);
    wr(A_STS, 32'h3);
    repeat (2)
    fork
      wr(A_CTL, 32'h5D);
      hichk(0, 40, 5, "pulse");
    join
    rdchk(A_CTL, 32'h1, 32'h0, "run");
    rdchk(A_STS, 32'h1, 32'h1, "aflag");
    fork
      i_pins.blip(1'h1, 2);
      hichk(0, 40, 5, "trigger");
    join
    // Capture: mode 01, edges off, period 16
    wr(A_CTL, 32'h0);
    wr(A_CMP, 32'h0);
    wr(A_PER, 32'h10);
    wr(A_STS, 32'h3);
    wr(A_CTL, 32'h1B);
    i_pins.blip(1'h0, 4);
    repeat (20) @(posedge aclk);
    rdchk(A_CMP, 32'hFFFF, 32'h0, "off");
    rdchk(A_STS, 32'h3, 32'h2, "wrap");
    rd(A_CNT, v);
    chk(v[31:16] < 16'h10, 1'h1, "limit");
    wr(A_PER, 32'h0);
    wr(A_CTL, 32'h3);
    i_pins.blip(1'h1, 4);
    repeat (20) @(posedge aclk);
    rdchk(A_STS, 32'h1, 32'h0, "source");
    rd(A_CNT, v);
    chk(v[31:16] > 16'h10, 1'h1, "range");
    i_pins.blip(1'h0, 4);
    repeat (20) @(posedge aclk);
    rd(A_CMP, v);
    rd(A_CNT, u);
    chk(v != 0 && v[15:0] < u[31:16], 1'h1, "latch");
    rdchk(A_STS, 32'h1, 32'h1, "cflag");
    wr(A_STS, 32'h3);
    wr(A_CTL, 32'h103);
    i_pins.blip(1'h1, 4);
    repeat (20) @(posedge aclk);
    rdchk(A_STS, 32'h1, 32'h1, "ext");
    close_out();
  end
endmodule : ptpc_timer_test
